// file: core/sbsp_pkg.sv
package sbsp_pkg;

	// Word geometry of the memory behind the port
	localparam int ADDR_W = 21;
	localparam int LANES  = 4;
	localparam int CNT_W  = 2;

	localparam logic [LANES-1:0] LANES_ALL  = 4'hf;
	localparam logic [LANES-1:0] LANES_NONE = 4'h0;
	localparam logic [CNT_W-1:0] CNT_RST    = 2'h0;
	localparam logic [CNT_W-1:0] CNT_ONE    = 2'h1;

	// Burst order select levels
	localparam logic ORDER_LINEAR      = 1'b0;
	localparam logic ORDER_INTERLEAVED = 1'b1;

	// Address and select controls sampled on each rising edge
	typedef struct packed {
		logic proc_strobe_n;
		logic ctrl_strobe_n;
		logic advance_n;
		logic chip_sel_first_n;
		logic chip_sel_second;
		logic chip_sel_third_n;
	} sbsp_ctl_s;

	// Write controls sampled on each rising edge
	typedef struct packed {
		logic             write_all_bytes_n;
		logic             byte_write_qualifier_n;
		logic [LANES-1:0] byte_sel_n;
	} sbsp_wr_s;

endpackage

// file: core/sbsp_burst_ctr.sv
module sbsp_burst_ctr #(
	parameter int CNT_W = sbsp_pkg::CNT_W
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_load,
	input  wire logic [CNT_W-1:0] i_load_val,
	input  wire logic             i_step,
	input  wire logic             i_interleaved,
	output logic      [CNT_W-1:0] o_low
);

	logic [CNT_W-1:0] start_r;
	logic [CNT_W-1:0] seq_r;
	logic [CNT_W-1:0] low_r;
	logic [CNT_W-1:0] seq_nxt;
	logic [CNT_W-1:0] low_nxt;

	// Low word bits for a given step count; wraps inside the group
	function automatic logic [CNT_W-1:0] burst_low(
		input logic [CNT_W-1:0] start,
		input logic [CNT_W-1:0] seq,
		input logic             inter
	);
		logic [CNT_W:0] sum;
		sum = {1'b0, start} + {1'b0, seq};
		if (inter == sbsp_pkg::ORDER_INTERLEAVED) begin
			return start ^ seq;
		end
		return sum[CNT_W-1:0];
	endfunction

	assign seq_nxt = CNT_W'(seq_r + CNT_W'(1));
	assign low_nxt = burst_low(start_r, seq_nxt, i_interleaved);

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_r <= '0;
			seq_r   <= '0;
			low_r   <= '0;
		end else if (i_load) begin
			start_r <= i_load_val;
			seq_r   <= '0;
			low_r   <= i_load_val;
		end else if (i_step) begin
			seq_r <= seq_nxt;
			low_r <= low_nxt;
		end
	end

	assign o_low = low_r;

	property p_interleave_step;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(!i_load && i_step && i_interleaved && seq_r == '0)
		|=> (low_r == ($past(start_r) ^ CNT_W'(1)));
	endproperty
	a_interleave_step: assert property (p_interleave_step)
		else $error("interleaved first step wrong");

endmodule

// file: core/sbsp_port.sv
module sbsp_port #(
	parameter int ADDR_W = sbsp_pkg::ADDR_W
) (
	input  wire logic                       i_core_clk,
	input  wire logic                       i_rst_n,
	input  wire logic [ADDR_W-1:0]          i_addr,
	input  wire logic                       i_processor_addr_strobe_n,
	input  wire logic                       i_controller_addr_strobe_n,
	input  wire logic                       i_advance_n,
	input  wire logic                       i_chip_sel_first_n,
	input  wire logic                       i_chip_sel_second,
	input  wire logic                       i_chip_sel_third_n,
	input  wire logic                       i_write_all_bytes_n,
	input  wire logic                       i_byte_write_qualifier_n,
	input  wire logic                       i_byte_sel_lane0_n,
	input  wire logic                       i_byte_sel_lane1_n,
	input  wire logic                       i_byte_sel_lane2_n,
	input  wire logic                       i_byte_sel_lane3_n,
	input  wire logic                       i_burst_interleaved,
	input  wire logic                       i_out_en_n,
	output logic      [ADDR_W-1:0]          o_mem_addr,
	output logic                            o_selected,
	output logic      [sbsp_pkg::LANES-1:0] o_write_lanes,
	output logic                            o_read_cycle,
	output logic                            o_dq_oe
);

	localparam int CW = sbsp_pkg::CNT_W;
	localparam int LN = sbsp_pkg::LANES;

	sbsp_pkg::sbsp_ctl_s ctl;
	sbsp_pkg::sbsp_wr_s  wr;

	logic                 proc_load;
	logic                 ctrl_load;
	logic                 load;
	logic                 ce_active;
	logic                 sel_nxt;
	logic                 capture;
	logic                 step;
	logic [LN-1:0]        lanes_req;
	logic [LN-1:0]        wr_nxt;
	logic                 read_nxt;
	logic                 drive_ok_nxt;
	logic [CW-1:0]        low_addr;

	logic                 sel_r;
	logic [ADDR_W-1:CW]   base_r;
	logic [LN-1:0]        wr_r;
	logic                 read_r;
	logic                 drive_ok_r;

	assign ctl = '{
		proc_strobe_n:    i_processor_addr_strobe_n,
		ctrl_strobe_n:    i_controller_addr_strobe_n,
		advance_n:        i_advance_n,
		chip_sel_first_n: i_chip_sel_first_n,
		chip_sel_second:  i_chip_sel_second,
		chip_sel_third_n: i_chip_sel_third_n
	};

	assign wr = '{
		write_all_bytes_n:      i_write_all_bytes_n,
		byte_write_qualifier_n: i_byte_write_qualifier_n,
		byte_sel_n:             {i_byte_sel_lane3_n, i_byte_sel_lane2_n,
		                         i_byte_sel_lane1_n, i_byte_sel_lane0_n}
	};

	// Address load decode; the controller strobe loads regardless of enables
	assign proc_load = !ctl.proc_strobe_n && !ctl.chip_sel_first_n;
	assign ctrl_load = !ctl.ctrl_strobe_n;
	assign load      = proc_load || ctrl_load;

	assign ce_active = !ctl.chip_sel_first_n && ctl.chip_sel_second
		&& !ctl.chip_sel_third_n;

	// Enables count only when a new address is taken
	assign sel_nxt = load ? ce_active : sel_r;
	assign capture = load && ce_active;

	// Advance steps the burst only on a continuation cycle
	assign step = sel_r && !load && !ctl.advance_n;

	// Global write overrides the byte selects and the qualifier
	assign lanes_req = !wr.write_all_bytes_n ? sbsp_pkg::LANES_ALL
		: (!wr.byte_write_qualifier_n ? ~wr.byte_sel_n
		: sbsp_pkg::LANES_NONE);

	assign wr_nxt   = sel_nxt ? lanes_req : sbsp_pkg::LANES_NONE;
	assign read_nxt = sel_nxt && (wr_nxt == sbsp_pkg::LANES_NONE);

	// A read that starts from deselect keeps the pins off for its first clock
	assign drive_ok_nxt = read_nxt && sel_r;

	sbsp_burst_ctr #(
		.CNT_W (CW)
	) u_ctr (
		.i_core_clk    (i_core_clk),
		.i_rst_n       (i_rst_n),
		.i_load        (capture),
		.i_load_val    (i_addr[CW-1:0]),
		.i_step        (step),
		.i_interleaved (i_burst_interleaved),
		.o_low         (low_addr)
	);

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sel_r      <= 1'b0;
			base_r     <= '0;
			wr_r       <= sbsp_pkg::LANES_NONE;
			read_r     <= 1'b0;
			drive_ok_r <= 1'b0;
		end else begin
			sel_r      <= sel_nxt;
			wr_r       <= wr_nxt;
			read_r     <= read_nxt;
			drive_ok_r <= drive_ok_nxt;
			if (capture) begin
				base_r <= i_addr[ADDR_W-1:CW];
			end
		end
	end

	assign o_mem_addr    = {base_r, low_addr};
	assign o_selected    = sel_r;
	assign o_write_lanes = wr_r;
	assign o_read_cycle  = read_r;

	// Output enable is not clocked: it gates the registered drive window
	assign o_dq_oe = drive_ok_r && !i_out_en_n;

	property p_capture;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		capture |=> (o_selected && o_mem_addr == $past(i_addr));
	endproperty
	a_capture: assert property (p_capture)
		else $error("address not captured on load");

	property p_low_bits;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		capture |=> (low_addr == $past(i_addr[CW-1:0]));
	endproperty
	a_low_bits: assert property (p_low_bits)
		else $error("counter not loaded from low address bits");

	property p_global_write;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(sel_nxt && !i_write_all_bytes_n)
		|=> (o_write_lanes == sbsp_pkg::LANES_ALL);
	endproperty
	a_global_write: assert property (p_global_write)
		else $error("global write missed a lane");

	property p_byte_qualify;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_write_all_bytes_n && i_byte_write_qualifier_n)
		|=> (o_write_lanes == sbsp_pkg::LANES_NONE && !o_dq_oe
			|| o_write_lanes == sbsp_pkg::LANES_NONE);
	endproperty
	a_byte_qualify: assert property (p_byte_qualify)
		else $error("byte write without qualifier");

	property p_hold_no_adv;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(o_selected && !load && i_advance_n) |=> $stable(o_mem_addr);
	endproperty
	a_hold_no_adv: assert property (p_hold_no_adv)
		else $error("burst address moved without advance");

	property p_deselect;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(load && !ce_active) |=> !o_selected;
	endproperty
	a_deselect: assert property (p_deselect)
		else $error("inactive enable did not deselect");

	property p_ce_ignored;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(o_selected && !load && !ce_active) |=> o_selected;
	endproperty
	a_ce_ignored: assert property (p_ce_ignored)
		else $error("enable acted on burst continuation");

	property p_proc_ignored;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(!i_processor_addr_strobe_n && i_chip_sel_first_n
			&& i_controller_addr_strobe_n && i_advance_n)
		|=> ($stable(o_mem_addr) && $stable(o_selected));
	endproperty
	a_proc_ignored: assert property (p_proc_ignored)
		else $error("processor strobe taken with first enable high");

	property p_oe_level;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		i_out_en_n |-> !o_dq_oe;
	endproperty
	a_oe_level: assert property (p_oe_level)
		else $error("data driven while output enable high");

	property p_first_read;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(!o_selected ##1 o_read_cycle) |-> !o_dq_oe;
	endproperty
	a_first_read: assert property (p_first_read)
		else $error("data driven in first read after deselect");

	property p_wrap;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		step |=> (o_mem_addr[ADDR_W-1:CW] == $past(o_mem_addr[ADDR_W-1:CW]));
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("burst carried into upper address");

	c_full_burst: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
		capture ##1 step ##1 step ##1 step);
	c_global_write: cover property (@(posedge i_core_clk)
		disable iff (!i_rst_n) o_write_lanes == sbsp_pkg::LANES_ALL);
	c_read_drive: cover property (@(posedge i_core_clk)
		disable iff (!i_rst_n) o_read_cycle ##1 o_dq_oe);
	c_interleaved: cover property (@(posedge i_core_clk)
		disable iff (!i_rst_n) step && i_burst_interleaved);

endmodule

// file: tb/sbsp_host_model.sv
module sbsp_host_model #(
	parameter int ADDR_W = sbsp_pkg::ADDR_W
) (
	input  wire logic              i_core_clk,
	output sbsp_pkg::sbsp_ctl_s    o_ctl,
	output sbsp_pkg::sbsp_wr_s     o_wr,
	output logic      [ADDR_W-1:0] o_addr,
	output logic                   o_interleaved,
	output logic                   o_out_en_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// Strobes and advance high: the bus asks for nothing
	localparam sbsp_pkg::sbsp_ctl_s REST = 6'h3a;
	initial begin
		o_ctl = REST;
		o_wr = 6'h3f;
		o_addr = '0;
		o_interleaved = sbsp_pkg::ORDER_LINEAR;
		o_out_en_n = 1'b0;
	end
	// One request edge, then the bus rests; address lines stop holding
	task automatic xfer(input sbsp_pkg::sbsp_ctl_s c,
		input sbsp_pkg::sbsp_wr_s w, input logic [ADDR_W-1:0] a,
		input logic m);
		@(posedge i_core_clk);
		o_ctl <= c;
		o_wr <= w;
		o_addr <= a;
		o_interleaved <= m;
		@(posedge i_core_clk);
		o_ctl <= REST;
		o_wr <= 6'h3f;
		o_addr <= ~a;
		#1;
	endtask
	task automatic set_oe(input logic oe_n);
		@(posedge i_core_clk);
		o_out_en_n <= oe_n;
		#1;
	endtask
endmodule

// file: tb/sync_burst_sram_port_tb.sv
module sync_burst_sram_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int AW = sbsp_pkg::ADDR_W;
	localparam sbsp_pkg::sbsp_ctl_s LD_C  = 6'h2a;
	localparam sbsp_pkg::sbsp_ctl_s LD_P  = 6'h1a;
	localparam sbsp_pkg::sbsp_ctl_s LD_PX = 6'h1e;
	localparam sbsp_pkg::sbsp_ctl_s ADV   = 6'h32;
	localparam sbsp_pkg::sbsp_ctl_s ADVX  = 6'h36;
	localparam sbsp_pkg::sbsp_ctl_s HOLD  = 6'h3a;
	localparam sbsp_pkg::sbsp_wr_s  NO_WR = 6'h3f;
	logic                i_core_clk = 1'b0;
	logic                i_rst_n;
	sbsp_pkg::sbsp_ctl_s ctl;
	sbsp_pkg::sbsp_wr_s  wr;
	logic [AW-1:0]       addr;
	logic [AW-1:0]       mem_addr;
	logic                inter;
	logic                oe_n;
	logic                sel;
	logic                rd;
	logic                dq_oe;
	logic [3:0]          lanes;
	int                  fail_count = 0;
	int                  cmp_count = 0;

	always #25 i_core_clk = ~i_core_clk;

	sbsp_host_model u_sbsp_host_model (.i_core_clk(i_core_clk), .o_ctl(ctl),
		.o_wr(wr), .o_addr(addr), .o_interleaved(inter), .o_out_en_n(oe_n));

	sbsp_port u_sbsp_port (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_addr(addr), .i_processor_addr_strobe_n(ctl.proc_strobe_n),
		.i_controller_addr_strobe_n(ctl.ctrl_strobe_n),
		.i_advance_n(ctl.advance_n),
		.i_chip_sel_first_n(ctl.chip_sel_first_n),
		.i_chip_sel_second(ctl.chip_sel_second),
		.i_chip_sel_third_n(ctl.chip_sel_third_n),
		.i_write_all_bytes_n(wr.write_all_bytes_n),
		.i_byte_write_qualifier_n(wr.byte_write_qualifier_n),
		.i_byte_sel_lane0_n(wr.byte_sel_n[0]),
		.i_byte_sel_lane1_n(wr.byte_sel_n[1]),
		.i_byte_sel_lane2_n(wr.byte_sel_n[2]),
		.i_byte_sel_lane3_n(wr.byte_sel_n[3]),
		.i_burst_interleaved(inter), .i_out_en_n(oe_n),
		.o_mem_addr(mem_addr), .o_selected(sel), .o_write_lanes(lanes),
		.o_read_cycle(rd), .o_dq_oe(dq_oe));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic look(input logic [AW-1:0] a, input logic s,
		input logic [3:0] l, input logic r, input logic o);
		chk(mem_addr, a);
		chk(sel, s);
		chk(lanes, l);
		chk(rd, r);
		chk(dq_oe, o);
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic t_linear();
		logic [AW-1:0] a;
		a = 21'h0abcdd;
		u_sbsp_host_model.xfer(LD_C, NO_WR, a, 1'b0);
		look(a, 1'b1, 4'h0, 1'b1, 1'b0);
		for (int n = 1; n <= 4; n++) begin
			u_sbsp_host_model.xfer(ADV, NO_WR, ~a, 1'b0);
			look({a[AW-1:2], a[1:0] + 2'(n)}, 1'b1, 4'h0, 1'b1, 1'b1);
		end
		u_sbsp_host_model.xfer(HOLD, NO_WR, ~a, 1'b0);
		look(a, 1'b1, 4'h0, 1'b1, 1'b1);
		u_sbsp_host_model.set_oe(1'b1);
		chk(dq_oe, 1'b0);
		u_sbsp_host_model.set_oe(1'b0);
		chk(dq_oe, 1'b1);
	endtask

	task automatic t_inter();
		logic [AW-1:0] b;
		b = 21'h155551;
		u_sbsp_host_model.xfer(LD_P, NO_WR, b, 1'b1);
		look(b, 1'b1, 4'h0, 1'b1, 1'b1);
		for (int n = 1; n <= 3; n++) begin
			// The first enable goes inactive mid-burst and must not matter
			u_sbsp_host_model.xfer(n == 2 ? ADVX : ADV, NO_WR, ~b, 1'b1);
			look({b[AW-1:2], b[1:0] ^ 2'(n)}, 1'b1, 4'h0, 1'b1, 1'b1);
		end
	endtask

	task automatic t_write();
		sbsp_pkg::sbsp_wr_s wv [4] = '{6'h1f, 6'h05, 6'h25, 6'h30};
		logic [3:0] lv [4] = '{4'hf, 4'hf, 4'ha, 4'h0};
		logic [AW-1:0] c;
		c = 21'h000123;
		for (int i = 0; i < 4; i++) begin
			u_sbsp_host_model.xfer(LD_C, wv[i], c, 1'b0);
			look(c, 1'b1, lv[i], lv[i] == 4'h0, lv[i] == 4'h0);
		end
		u_sbsp_host_model.xfer(ADV, 6'h1f, ~c, 1'b0);
		look(21'h000120, 1'b1, 4'hf, 1'b0, 1'b0);
	endtask

	task automatic t_desel();
		sbsp_pkg::sbsp_ctl_s pv [3] = '{6'h2e, 6'h28, 6'h2b};
		logic [AW-1:0] d;
		d = 21'h1ffffd;
		u_sbsp_host_model.xfer(LD_C, NO_WR, d, 1'b0);
		u_sbsp_host_model.xfer(LD_PX, NO_WR, ~d, 1'b0);
		look(d, 1'b1, 4'h0, 1'b1, 1'b1);
		for (int i = 0; i < 3; i++) begin
			u_sbsp_host_model.xfer(LD_C, NO_WR, d, 1'b0);
			u_sbsp_host_model.xfer(pv[i], NO_WR, ~d, 1'b0);
			chk(sel, 1'b0);
			chk(dq_oe, 1'b0);
		end
		u_sbsp_host_model.xfer(LD_C, NO_WR, d, 1'b0);
		look(d, 1'b1, 4'h0, 1'b1, 1'b0);
	endtask

	initial begin
		i_rst_n = 1'b0;
		repeat (4) @(posedge i_core_clk);
		#1;
		look('0, 1'b0, 4'h0, 1'b0, 1'b0);
		@(posedge i_core_clk);
		i_rst_n <= 1'b1;
		t_linear();
		t_inter();
		t_write();
		t_desel();
		test_done();
	end

	// About 55 cycles of traffic expected; give over seven times that
	initial begin
		#(50 * 400);
		fail_count++;
		test_done();
	end
endmodule
